// file: rtl/vje_consts.svh
// vsync jitter eliminator constants: register offsets, field positions, resets
// assumes a byte-wide register port with 12-bit addresses and a 125 MHz clock
// Overview of operation
// - source select 0 passes raw vertical sync, 1 passes corrected sync while jitter removal is on, raw otherwise
// - auto field bit 0 disables field determination, 1 enables it
// - jitter removal runs only while control bit 2 holds 1
// - measure vertical sync falling edge phase against horizontal falling edges
// - vertical edge within a quarter line of horizontal edge snaps to fixed point
// - status holds read-only three-bit phase, one of eight phases
// - field flag 1 marks first dot-row field, 0 marks second
// - field flag names an overlay field, not the broadcast field
// - with jitter removal off only the second field is shown
// - with auto field cleared only the second field is shown
// - field decision comes from raw horizontal and vertical syncs

`ifndef VJE_CONSTS_SVH
`define VJE_CONSTS_SVH

// register offsets
`define VJE_CTRL_ADDR   12'hfe4
`define VJE_STAT_ADDR   12'hfe5

// control fields
`define VJE_BIT_SRCSEL  4
`define VJE_BIT_AUTOFLD 3
`define VJE_BIT_JREN    2
`define VJE_CTRL_RESET  8'h00

// status fields
`define VJE_BIT_FIELD   7
`define VJE_PHASE_HI    6
`define VJE_PHASE_LO    4

// line counter ceiling
`define VJE_CNT_MAX     14'h3fff

`endif

// file: rtl/vje_pkg.sv
// vsync jitter eliminator shared types
// assumes the constants header is compiled alongside
`default_nettype none

package vje_pkg;

  typedef enum logic [1:0] {
    VJE_IDLE       = 2'b00,
    VJE_WAIT_EDGE  = 2'b01,
    VJE_WAIT_POINT = 2'b11,
    VJE_LOW        = 2'b10
  } vje_state_e;

  typedef logic [13:0] vje_cnt_t;
  typedef logic [2:0]  vje_phase_t;

endpackage : vje_pkg

`default_nettype wire

// file: rtl/vje_top.sv
// vsync jitter eliminator: phase detector, sync snapping, field decision
// assumes active-low syncs synchronous to ref_clk and a one-cycle strobe port
//
// Strobed register access was chosen for this implementation.
`include "vje_consts.svh"
`default_nettype none

module vje_top
  import vje_pkg::*;
(
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  // register port
  input  wire logic [11:0] regAddr,
  input  wire logic [7:0]  regWdata,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output var  logic [7:0]  regRdata,
  // syncs from the video source
  input  wire logic        horizontalSyncIn_n,
  input  wire logic        verticalSyncIn_n,
  // syncs and field to the screen overlay
  output var  logic        hsyncOut_n,
  output var  logic        vsyncOut_n,
  output var  logic        fieldDetectFlag
);

  // phase of a line position in eighths of the line period
  function automatic vje_phase_t phaseOf(input vje_cnt_t cnt, input vje_cnt_t per);
    logic [16:0] scaled;
    logic [16:0] acc;
    vje_phase_t  ph;
    scaled = {cnt, 3'b000};
    acc    = 17'h00000;
    ph     = 3'h0;
    for (int k = 1; k < 8; k++) begin
      acc = acc + {3'b000, per};
      if (scaled >= acc) begin
        ph = 3'(k);
      end
    end
    return ph;
  endfunction

  // control register
  logic       srcSel;
  logic       autoField;
  logic       jitterEn;

  // sync edge tracking
  logic       vPrev_n;
  vje_cnt_t   hCnt;
  vje_cnt_t   hPeriod;

  // status
  vje_phase_t phaseInd;
  logic [7:0] statusWord;

  // snapping machine
  vje_state_e state;
  vje_state_e next_state;
  vje_cnt_t   target;
  vje_cnt_t   next_target;
  logic       snapV_n;
  logic       next_snapV_n;

  // decode
  wire logic       ctrlWrite = regWr && (regAddr == `VJE_CTRL_ADDR);
  wire logic       statRead  = regRd && (regAddr == `VJE_STAT_ADDR);

  // edges, the previous horizontal level is the registered output
  wire logic       hFall = hsyncOut_n & ~horizontalSyncIn_n;
  wire logic       vFall = vPrev_n & ~verticalSyncIn_n;

  wire vje_cnt_t   hCntInc   = (hCnt == `VJE_CNT_MAX) ? hCnt : hCnt + 14'h0001;
  wire vje_cnt_t   quarterPt = {2'b00, hPeriod[13:2]};
  wire vje_cnt_t   threeQPt  = quarterPt + {1'b0, hPeriod[13:1]};

  // phase and closeness to a horizontal edge
  wire vje_phase_t livePhase = phaseOf(hCnt, hPeriod);
  wire logic       lateNear  = (livePhase >= 3'h6);
  wire logic       nearEdge  = (livePhase <= 3'h1) || lateNear;

  // field choice for the overlay
  wire logic       fieldOn   = jitterEn & autoField;
  wire logic       nextField = fieldOn & nearEdge;

  // corrected sync when enabled, raw sync otherwise
  wire logic       routedV_n = (srcSel && jitterEn) ? snapV_n : verticalSyncIn_n;

  // control register writes
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      srcSel    <= 1'b0;
      autoField <= 1'b0;
      jitterEn  <= 1'b0;
    end else if (ctrlWrite) begin
      srcSel    <= regWdata[`VJE_BIT_SRCSEL];
      autoField <= regWdata[`VJE_BIT_AUTOFLD];
      jitterEn  <= regWdata[`VJE_BIT_JREN];
    end
  end

  // sync edge history
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      hsyncOut_n <= 1'b1;
      vPrev_n    <= 1'b1;
    end else begin
      hsyncOut_n <= horizontalSyncIn_n;
      vPrev_n    <= verticalSyncIn_n;
    end
  end

  // position within the line and measured line length
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      hCnt <= 14'h0000;
    end else if (hFall) begin
      hCnt <= 14'h0000;
    end else begin
      hCnt <= hCntInc;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      hPeriod <= 14'h0000;
    end else if (hFall) begin
      hPeriod <= hCntInc;
    end
  end

  // phase and field captured once per vertical edge
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      phaseInd        <= 3'h0;
      fieldDetectFlag <= 1'b0;
    end else if (vFall) begin
      phaseInd        <= livePhase;
      fieldDetectFlag <= nextField;
    end
  end

  // snapping machine next state
  always_comb begin
    next_state   = state;
    next_target  = target;
    next_snapV_n = snapV_n;
    unique case (state)
      VJE_IDLE: begin
        if (vFall && jitterEn) begin
          next_target = nearEdge ? quarterPt : threeQPt;
          next_state  = lateNear ? VJE_WAIT_EDGE : VJE_WAIT_POINT;
        end
      end
      VJE_WAIT_EDGE: begin
        if (hFall) begin
          next_state = VJE_WAIT_POINT;
        end
      end
      VJE_WAIT_POINT: begin
        if (!hFall && (hCnt == target)) begin
          next_state   = VJE_LOW;
          next_snapV_n = 1'b0;
        end
      end
      VJE_LOW: begin
        if (verticalSyncIn_n && !hFall && (hCnt == target)) begin
          next_state   = VJE_IDLE;
          next_snapV_n = 1'b1;
        end
      end
    endcase
    if (!jitterEn) begin
      next_state   = VJE_IDLE;
      next_snapV_n = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state   <= VJE_IDLE;
      target  <= 14'h0000;
      snapV_n <= 1'b1;
    end else begin
      state   <= next_state;
      target  <= next_target;
      snapV_n <= next_snapV_n;
    end
  end

  // vertical sync to the overlay
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      vsyncOut_n <= 1'b1;
    end else begin
      vsyncOut_n <= routedV_n;
    end
  end

  // status word, reserved bits read zero
  always_comb begin
    statusWord                            = 8'h00;
    statusWord[`VJE_BIT_FIELD]            = fieldDetectFlag;
    statusWord[`VJE_PHASE_HI:`VJE_PHASE_LO] = phaseInd;
  end

  // read data for one cycle, zero otherwise and for the write-only control
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      regRdata <= 8'h00;
    end else begin
      regRdata <= statRead ? statusWord : 8'h00;
    end
  end

  // checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);

  sequence s_near_arm;
    (state == VJE_IDLE) && vFall && jitterEn && nearEdge && !lateNear;
  endsequence

  sequence s_late_arm;
    (state == VJE_IDLE) && vFall && jitterEn && lateNear;
  endsequence

  sequence s_mid_arm;
    (state == VJE_IDLE) && vFall && jitterEn && !nearEdge;
  endsequence

  sequence s_release;
    (state == VJE_LOW) && jitterEn && verticalSyncIn_n && !hFall && (hCnt == target);
  endsequence

  a_ctrl_bits: assert property (
    ctrlWrite |=> (jitterEn == $past(regWdata[`VJE_BIT_JREN]))
      && (autoField == $past(regWdata[`VJE_BIT_AUTOFLD]))
      && (srcSel == $past(regWdata[`VJE_BIT_SRCSEL])))
    else $error("control bits not taken from write");

  a_jitter_off: assert property (
    !jitterEn |=> (state == VJE_IDLE) && snapV_n)
    else $error("snapping active while disabled");

  a_raw_route: assert property (
    !srcSel |=> (vsyncOut_n == $past(verticalSyncIn_n)))
    else $error("raw vertical sync not routed");

  a_snap_route: assert property (
    (srcSel && jitterEn) |=> (vsyncOut_n == $past(snapV_n)))
    else $error("corrected vertical sync not routed");

  a_near_arm: assert property (
    s_near_arm |=> (state == VJE_WAIT_POINT) && (target == $past(quarterPt)))
    else $error("near edge not snapped to quarter point");

  a_late_arm: assert property (
    s_late_arm |=> (state == VJE_WAIT_EDGE) && (target == $past(quarterPt)))
    else $error("late edge not held for next line");

  a_mid_arm: assert property (
    s_mid_arm |=> (state == VJE_WAIT_POINT) && (target == $past(threeQPt)))
    else $error("mid line edge not snapped to three quarter point");

  a_snap_point: assert property (
    $fell(snapV_n) |-> ($past(hCnt) == target) && ($past(state) == VJE_WAIT_POINT))
    else $error("corrected sync fell off its fixed point");

  a_phase_capture: assert property (
    vFall |=> (phaseInd == phaseOf($past(hCnt), $past(hPeriod))))
    else $error("phase not captured at vertical edge");

  a_phase_hold: assert property (
    !vFall |=> $stable(phaseInd) && $stable(fieldDetectFlag))
    else $error("phase or field changed between vertical edges");

  a_field_jren: assert property (
    (vFall && !jitterEn) |=> !fieldDetectFlag)
    else $error("first field shown with jitter removal off");

  a_field_auto: assert property (
    (vFall && !autoField) |=> !fieldDetectFlag)
    else $error("first field shown with auto field off");

  a_field_near: assert property (
    (vFall && jitterEn && autoField) |=> (fieldDetectFlag == $past(nearEdge)))
    else $error("field flag does not follow edge phase");

  a_status_read: assert property (
    statRead |=> (regRdata[`VJE_PHASE_HI:`VJE_PHASE_LO] == $past(phaseInd))
      && (regRdata[`VJE_BIT_FIELD] == $past(fieldDetectFlag))
      && (regRdata[`VJE_PHASE_LO-1:0] == 4'h0))
    else $error("status read data wrong");

  a_rdata_idle: assert property (
    !statRead |=> (regRdata == 8'h00))
    else $error("read data not zero outside a status read");

  a_snap_release: assert property (
    s_release |=> (state == VJE_IDLE) && snapV_n)
    else $error("corrected sync not released at its fixed point");

  a_low_hold: assert property (
    (state == VJE_LOW) && jitterEn && !verticalSyncIn_n |=> (state == VJE_LOW) && !snapV_n)
    else $error("corrected sync released while raw sync low");

  a_wait_edge: assert property (
    (state == VJE_WAIT_EDGE) && jitterEn && hFall |=> (state == VJE_WAIT_POINT))
    else $error("late edge not moved to next line");

  a_edge_hold: assert property (
    (state == VJE_WAIT_EDGE) && jitterEn && !hFall |=> (state == VJE_WAIT_EDGE) && snapV_n)
    else $error("late edge wait left early");

  a_point_wait: assert property (
    (state == VJE_WAIT_POINT) && jitterEn && (hCnt != target)
      |=> (state == VJE_WAIT_POINT) && snapV_n)
    else $error("corrected sync fell before its fixed point");

  a_idle_quiet: assert property (
    (state == VJE_IDLE) && !(vFall && jitterEn) |=> (state == VJE_IDLE) && snapV_n)
    else $error("snapping started without a vertical edge");

  a_line_start: assert property (
    hFall |=> (hCnt == 14'h0000))
    else $error("line position not cleared at horizontal edge");

  a_line_count: assert property (
    !hFall && (hCnt != `VJE_CNT_MAX) |=> (hCnt == $past(hCnt) + 14'h0001))
    else $error("line position not counting");

  a_period_take: assert property (
    hFall && (hCnt != `VJE_CNT_MAX) |=> (hPeriod == $past(hCnt) + 14'h0001))
    else $error("line period not measured");

  a_ctrl_hold: assert property (
    !ctrlWrite |=> $stable(srcSel) && $stable(autoField) && $stable(jitterEn))
    else $error("control bits changed without a write");

  a_hsync_pass: assert property (
    1'b1 |=> (hsyncOut_n == $past(horizontalSyncIn_n)))
    else $error("horizontal sync not passed to overlay");

  a_disabled_raw: assert property (
    (srcSel && !jitterEn) |=> (vsyncOut_n == $past(verticalSyncIn_n)))
    else $error("raw vertical sync not routed while removal off");

endmodule // vje_top

`default_nettype wire

// file: tb/vje_sync_source.sv
// vje_sync_source: video source model, 64-cycle lines, 10-line frames
// assumes vOffset is taken at each frame start, syncs active low
`default_nettype none

module vje_sync_source (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  // vertical edge position within its line
  input  wire logic [5:0] vOffset,
  // syncs to the block
  output var  logic       hSync_n,
  output var  logic       vSync_n
);
  logic [5:0] lineCnt;
  logic [3:0] lineNum;
  logic [5:0] offHeld;
  wire  logic inV;

  // vertical low from line 2 at offset to line 5 at offset
  assign inV = (lineNum > 4'h2 && lineNum < 4'h5) || (lineNum == 4'h2 && lineCnt >= offHeld)
             || (lineNum == 4'h5 && lineCnt < offHeld);

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      lineCnt <= 6'h00;
      lineNum <= 4'h0;
      offHeld <= vOffset;
      hSync_n <= 1'b1;
      vSync_n <= 1'b1;
    end else begin
      lineCnt <= lineCnt + 6'h01;
      if (lineCnt == 6'h3f) lineNum <= (lineNum == 4'h9) ? 4'h0 : lineNum + 4'h1;
      if (lineCnt == 6'h3f && lineNum == 4'h9) offHeld <= vOffset;
      hSync_n <= lineCnt >= 6'h08;
      vSync_n <= !inV;
    end
  end
endmodule // vje_sync_source

`default_nettype wire

// file: tb/testbench.sv
// testbench: register tasks and sync scenarios for the jitter eliminator
// assumes the source model frame of 640 cycles and a 125 MHz clock
`include "vje_consts.svh"
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  logic        ref_clk;
  logic        sys_rst;
  logic [11:0] regAddr;
  logic [7:0]  regWdata;
  logic        regWr;
  logic        regRd;
  logic [7:0]  regRdata;
  logic [5:0]  vOffset;
  logic        hIn_n;
  logic        vIn_n;
  logic        hOut_n;
  logic        vOut_n;
  logic        fieldFlag;
  logic        hPrev;
  logic        vPrev;
  logic [7:0]  hPos;
  logic [7:0]  vFallPos;
  logic [7:0]  d;
  logic [7:0]  posA;
  logic [7:0]  posB;
  logic [7:0]  hMiss;
  int          errTotal;
  int          compares;

  vje_top i_vje_top (.ref_clk(ref_clk), .sys_rst(sys_rst), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .horizontalSyncIn_n(hIn_n), .verticalSyncIn_n(vIn_n), .hsyncOut_n(hOut_n),
    .vsyncOut_n(vOut_n), .fieldDetectFlag(fieldFlag));

  vje_sync_source i_vje_sync_source (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .vOffset(vOffset), .hSync_n(hIn_n), .vSync_n(vIn_n));

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  // position of the overlay vertical fall after the raw horizontal fall
  always @(posedge ref_clk) begin
    hPrev <= hIn_n;
    vPrev <= vOut_n;
    hPos <= (hPrev && !hIn_n) ? 8'h00 : hPos + 8'h01;
    if (vPrev && !vOut_n) vFallPos <= hPos;
    if (!sys_rst && (hOut_n !== hPrev) && (hMiss != 8'hff)) begin
      hMiss <= hMiss + 8'h01;
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      errTotal++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= v;
    @(posedge ref_clk);
    regWr <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, output logic [7:0] v);
    @(posedge ref_clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge ref_clk);
    regRd <= 1'b0;
    #1 v = regRdata;
  endtask

  task automatic meas(input logic [5:0] off, output logic [7:0] pos);
    vOffset <= off;
    repeat (3 * 640) @(posedge ref_clk);
    pos = vFallPos;
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", compares, errTotal);
    if (errTotal == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  initial begin
    errTotal = 0;
    compares = 0;
    sys_rst = 1'b1;
    regAddr = 12'h000;
    regWdata = 8'h00;
    regWr = 1'b0;
    regRd = 1'b0;
    vOffset = 6'h04;
    hPrev = 1'b1;
    vPrev = 1'b1;
    hPos = 8'h00;
    vFallPos = 8'h00;
    hMiss = 8'h00;
    repeat (8) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rd(`VJE_CTRL_ADDR, d);
    chk(d, 8'h00);
    rd(12'hfe6, d);
    chk(d, 8'h00);
    wr(`VJE_CTRL_ADDR, 8'h1c);
    wr(12'hfe6, 8'h00);
    // every phase: code, near-edge field decision, corrected fall position
    for (int p = 0; p < 8; p++) begin
      meas(6'(p * 8 + 4), posA);
      chk(posA, (p < 2 || p > 5) ? 8'h12 : 8'h32);
      rd(`VJE_STAT_ADDR, d);
      chk(d, {(p < 2 || p > 5), 3'(p), 4'h0});
    end
    repeat (200) @(posedge ref_clk);
    rd(`VJE_STAT_ADDR, posB);
    chk(posB, d);
    // corrected fall sits at one place for near-edge phases 0 and 1
    meas(6'h04, posA);
    meas(6'h0c, posB);
    chk(posB, posA);
    wr(`VJE_CTRL_ADDR, 8'h04);
    meas(6'h04, posA);
    chk(posA, 8'h04);
    rd(`VJE_STAT_ADDR, d);
    chk(d, 8'h00);
    // raw routing follows the source edge cycle for cycle
    meas(6'h0c, posB);
    chk(posB - posA, 8'h08);
    wr(`VJE_CTRL_ADDR, 8'h18);
    meas(6'h04, posA);
    chk(posA, 8'h04);
    rd(`VJE_STAT_ADDR, d);
    chk({d[7], 7'h00}, 8'h00);
    chk({fieldFlag, 7'h00}, 8'h00);
    wr(`VJE_CTRL_ADDR, 8'h00);
    meas(6'h04, posA);
    chk(posA, 8'h04);
    rd(`VJE_STAT_ADDR, d);
    chk({d[7], 7'h00}, 8'h00);
    chk(hMiss, 8'h00);
    final_report();
  end
endmodule // testbench

`default_nettype wire
